// ==== lt_cfg.svh ====
// Purpose: Constants for the indicator lamp test sequencer.
// Assumes: 200 MHz system clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
`ifndef LT_CFG_SVH
`define LT_CFG_SVH

`define LT_CLK_HZ 200000000
`define LT_QUAL_MS 250
`define LT_STEP_S 1
`define LT_STAGE1_S 60
`define LT_LAMPS 62
`define LT_IDX_W 6
`define LT_LAST_IDX 6'h3D
`define LT_NTRIG 8
`define LT_SEL_W 3
`define LT_TMR_W 36
`define LT_QCNT_W 26

`define LT_ADDR_CTRL 4'h0
`define LT_ADDR_STAT 4'h4
`define LT_ADDR_FLO 4'h8
`define LT_ADDR_FHI 4'hC

`define LT_CTRL_EN 0
`define LT_CTRL_SEL_LO 1
`define LT_STAT_ACT 0
`define LT_STAT_STG_LO 1
`define LT_STAT_IDX_LO 4
`define LT_STAT_INIT 16
`define LT_STAT_LVL 17

`endif

// ==== lt_pkg.sv ====
// Purpose: Types shared by the lamp test sequencer modules.
// Assumes: lt_cfg.svh supplies all widths except the 3-bit state code and the 32-bit read data.
// Notes: Each module keeps its whole state in one struct.
`include "lt_cfg.svh"

package lt_pkg;

    typedef enum logic [2:0] {
        LT_IDLE,
        LT_ALL_ON,
        LT_BLANK,
        LT_WALK_ON,
        LT_FULL,
        LT_WALK_OFF
    } lt_state_t;

    typedef struct packed {
        logic level;
        logic rise;
        logic [`LT_QCNT_W-1:0] cnt;
    } lt_qual_st_t;

    typedef struct packed {
        lt_state_t state;
        logic active;
        logic [`LT_TMR_W-1:0] tmr;
        logic [`LT_IDX_W-1:0] idx;
        logic [`LT_LAMPS-1:0] lamp;
        logic [`LT_LAMPS-1:0] shadow;
        logic en;
        logic [`LT_SEL_W-1:0] sel;
        logic init_seen;
        logic init_evt;
        logic tgt_clr;
        logic [`LT_NTRIG-1:0] trig_s1;
        logic [`LT_NTRIG-1:0] trig_s2;
        logic btn_s1;
        logic btn_s2;
        logic btn_prev;
        logic ack;
        logic [31:0] dat;
    } lt_top_st_t;

endpackage : lt_pkg

// ==== lt_qual.sv ====
// Purpose: Pulse-width qualifier for the synchronised test control input.
// Assumes: raw_i is already synchronised to clk_i.
// Notes: A change is accepted only after it has held QUAL_CYC cycles.
`timescale 1ns/1ps
`include "lt_cfg.svh"

module lt_qual #(
    parameter longint unsigned QUAL_CYC = 64'(`LT_CLK_HZ / 1000) * 64'(`LT_QUAL_MS)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    output logic level_o,
    output logic rise_o
);

    lt_pkg::lt_qual_st_t st;
    lt_pkg::lt_qual_st_t st_nxt;

    // Short glitches restart the count, so a bouncing contact never acts.
    always_comb begin
        st_nxt = st;
        st_nxt.rise = 1'b0;
        if (raw_i == st.level) begin
            st_nxt.cnt = '0;
        end else if (st.cnt == `LT_QCNT_W'(QUAL_CYC - 64'd1)) begin
            st_nxt.level = raw_i;
            st_nxt.rise = raw_i;
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st.cnt + `LT_QCNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= st_nxt;
        end
    end

    assign level_o = st.level;
    assign rise_o = st.rise;

endmodule : lt_qual

// ==== lt_seq.sv ====
// Purpose: Three-stage indicator lamp test sequencer with Wishbone registers.
// Assumes: func_lamp_i comes from logic on clk_i; trig_i and reset_btn_i are pins.
// Notes: Lamp bit k is the k-th lamp in column order from the top left panel.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "lt_cfg.svh"

// Behaviour
// - Start test from the selected trigger input when enable setting is on.
// - Drive all lamps, pushbutton lamps included.
// - Stage one lights all 62 lamps at once.
// - Stage one lasts while control held, at most one minute.
// - Control still held after one minute ends the whole test.
// - Stage two blanks all, then lights one lamp per second.
// - Stage two walks columns top to bottom from top left panel.
// - Stage three lights all, then darkens one lamp per second.
// - Stage three uses the same column order as stage two.
// - Stages two and three can be interrupted at any moment.
// - During the test only the sequence drives the lamps.
// - Functional lamp changes keep being stored in a shadow during test.
// - On end or abort lamps show shadow states at once.
// - Reset pushbutton clears no targets while the test runs.
// - Active flag held for whole test; start event logged.
// - Control pulses count only if held at least 250 ms.
// - Sequencer reacts to control level and to its rising edges.
// - Release in stage one starts stage two; stage two leads to three.
module lt_seq #(
    parameter longint unsigned QUAL_CYC = 64'(`LT_CLK_HZ / 1000) * 64'(`LT_QUAL_MS),
    parameter longint unsigned STEP_CYC = 64'(`LT_CLK_HZ) * 64'(`LT_STEP_S),
    parameter longint unsigned STAGE1_CYC = 64'(`LT_CLK_HZ) * 64'(`LT_STAGE1_S)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [`LT_NTRIG-1:0] trig_i,
    input wire logic reset_btn_i,
    input wire logic [`LT_LAMPS-1:0] func_lamp_i,
    output logic [`LT_LAMPS-1:0] lamp_o,
    output logic lamp_test_active_flag_o,
    output logic test_init_evt_o,
    output logic target_clear_o
);

    lt_pkg::lt_top_st_t st;
    lt_pkg::lt_top_st_t st_nxt;
    logic ctl_raw;
    logic ctl_level;
    logic ctl_rise;
    logic access;
    logic [1:0] stage;
    logic [`LT_TMR_W-1:0] step_last;
    logic [`LT_TMR_W-1:0] s1_last;

    assign step_last = `LT_TMR_W'(STEP_CYC - 64'd1);
    assign s1_last = `LT_TMR_W'(STAGE1_CYC - 64'd1);

    // The selected line is taken after the second synchroniser stage only.
    assign ctl_raw = st.trig_s2[st.sel];

    lt_qual #(
        .QUAL_CYC(QUAL_CYC)
    ) u_qual (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(ctl_raw),
        .level_o(ctl_level),
        .rise_o(ctl_rise)
    );

    assign access = wb_cyc_i & wb_stb_i & ~st.ack;

    always_comb begin
        unique case (st.state)
            lt_pkg::LT_ALL_ON: stage = 2'h1;
            lt_pkg::LT_BLANK, lt_pkg::LT_WALK_ON: stage = 2'h2;
            lt_pkg::LT_FULL, lt_pkg::LT_WALK_OFF: stage = 2'h3;
            default: stage = 2'h0;
        endcase
    end

    always_comb begin
        st_nxt = st;
        st_nxt.trig_s1 = trig_i;
        st_nxt.trig_s2 = st.trig_s1;
        st_nxt.btn_s1 = reset_btn_i;
        st_nxt.btn_s2 = st.btn_s1;
        st_nxt.btn_prev = st.btn_s2;
        st_nxt.init_evt = 1'b0;
        st_nxt.tgt_clr = 1'b0;
        st_nxt.ack = access;
        st_nxt.dat = '0;
        st_nxt.tmr = st.tmr + `LT_TMR_W'(1);

        // The shadow follows functional requests in every state.
        st_nxt.shadow = func_lamp_i;

        // A press of the reset button is swallowed while the test runs.
        if (st.btn_s2 && !st.btn_prev && st.state == lt_pkg::LT_IDLE) begin
            st_nxt.tgt_clr = 1'b1;
        end

        // Register writes; the start-event bit is write-one-to-clear.
        if (access && wb_we_i) begin
            if (wb_adr_i == `LT_ADDR_CTRL && wb_sel_i[0]) begin
                st_nxt.en = wb_dat_i[`LT_CTRL_EN];
                st_nxt.sel = wb_dat_i[`LT_CTRL_SEL_LO +: `LT_SEL_W];
            end
            if (wb_adr_i == `LT_ADDR_STAT && wb_sel_i[2] && wb_dat_i[`LT_STAT_INIT]) begin
                st_nxt.init_seen = 1'b0;
            end
        end

        if (access && !wb_we_i) begin
            unique case (wb_adr_i)
                `LT_ADDR_CTRL: begin
                    st_nxt.dat[`LT_CTRL_EN] = st.en;
                    st_nxt.dat[`LT_CTRL_SEL_LO +: `LT_SEL_W] = st.sel;
                end
                `LT_ADDR_STAT: begin
                    st_nxt.dat[`LT_STAT_ACT] = st.active;
                    st_nxt.dat[`LT_STAT_STG_LO +: 2] = stage;
                    st_nxt.dat[`LT_STAT_IDX_LO +: `LT_IDX_W] = st.idx;
                    st_nxt.dat[`LT_STAT_INIT] = st.init_seen;
                    st_nxt.dat[`LT_STAT_LVL] = ctl_level;
                end
                `LT_ADDR_FLO: st_nxt.dat = st.shadow[31:0];
                `LT_ADDR_FHI: st_nxt.dat = 32'(st.shadow[`LT_LAMPS-1:32]);
                default: st_nxt.dat = '0;
            endcase
        end

        unique case (st.state)
            lt_pkg::LT_IDLE: begin
                if (st.en && ctl_rise) begin
                    st_nxt.state = lt_pkg::LT_ALL_ON;
                    st_nxt.tmr = '0;
                    st_nxt.init_evt = 1'b1;
                    st_nxt.init_seen = 1'b1;
                end
            end
            lt_pkg::LT_ALL_ON: begin
                if (!ctl_level) begin
                    st_nxt.state = lt_pkg::LT_BLANK;
                    st_nxt.tmr = '0;
                end else if (st.tmr == s1_last) begin
                    st_nxt.state = lt_pkg::LT_IDLE;
                end
            end
            lt_pkg::LT_BLANK: begin
                if (st.tmr == step_last) begin
                    st_nxt.state = lt_pkg::LT_WALK_ON;
                    st_nxt.tmr = '0;
                    st_nxt.idx = '0;
                end
            end
            lt_pkg::LT_WALK_ON: begin
                if (st.tmr == step_last) begin
                    st_nxt.tmr = '0;
                    if (st.idx == `LT_LAST_IDX) begin
                        st_nxt.state = lt_pkg::LT_FULL;
                    end else begin
                        st_nxt.idx = st.idx + `LT_IDX_W'(1);
                    end
                end
            end
            lt_pkg::LT_FULL: begin
                if (st.tmr == step_last) begin
                    st_nxt.state = lt_pkg::LT_WALK_OFF;
                    st_nxt.tmr = '0;
                    st_nxt.idx = '0;
                end
            end
            lt_pkg::LT_WALK_OFF: begin
                if (st.tmr == step_last) begin
                    st_nxt.tmr = '0;
                    if (st.idx == `LT_LAST_IDX) begin
                        st_nxt.state = lt_pkg::LT_IDLE;
                    end else begin
                        st_nxt.idx = st.idx + `LT_IDX_W'(1);
                    end
                end
            end
            // Two state codes are unused; an upset into one of them drops back to idle.
            default: st_nxt.state = lt_pkg::LT_IDLE;
        endcase

        // Any qualified press after stage one aborts; clearing enable does too.
        if (stage[1] && (ctl_rise || !st.en)) begin
            st_nxt.state = lt_pkg::LT_IDLE;
        end
        if (st_nxt.state == lt_pkg::LT_IDLE) begin
            st_nxt.idx = '0;
        end
        // The flag is its own flip-flop so the output carries no decode logic.
        st_nxt.active = st_nxt.state != lt_pkg::LT_IDLE;

        // Lamps are computed from the next state so the handover is immediate.
        unique case (st_nxt.state)
            lt_pkg::LT_ALL_ON, lt_pkg::LT_FULL: st_nxt.lamp = '1;
            lt_pkg::LT_BLANK: st_nxt.lamp = '0;
            lt_pkg::LT_WALK_ON: st_nxt.lamp = `LT_LAMPS'(1) << st_nxt.idx;
            lt_pkg::LT_WALK_OFF: st_nxt.lamp = ~(`LT_LAMPS'(1) << st_nxt.idx);
            default: st_nxt.lamp = func_lamp_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= st_nxt;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.dat;
    assign lamp_o = st.lamp;
    assign lamp_test_active_flag_o = st.active;
    assign test_init_evt_o = st.init_evt;
    assign target_clear_o = st.tgt_clr;

endmodule : lt_seq

// ==== lt_seq_chk.sv ====
// Purpose: Port assertions for the lamp test sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees the top module's ports only.
`timescale 1ns/1ps
`include "lt_cfg.svh"
module lt_seq_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [`LT_LAMPS-1:0] func_lamp_i,
    input wire logic [`LT_LAMPS-1:0] lamp_o,
    input wire logic lamp_test_active_flag_o,
    input wire logic test_init_evt_o,
    input wire logic target_clear_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    chk_start_lit: assert property (
        test_init_evt_o |-> lamp_test_active_flag_o && (&lamp_o))
        else $error("start without all lamps lit");
    chk_start_evt: assert property ($rose(lamp_test_active_flag_o) |-> test_init_evt_o)
        else $error("test began without start event");
    chk_no_clear: assert property (target_clear_o |-> !$past(lamp_test_active_flag_o))
        else $error("target clear during test");
    chk_restore: assert property (
        $fell(lamp_test_active_flag_o) |-> lamp_o == $past(func_lamp_i))
        else $error("lamps not restored at end");
    chk_follow: assert property (
        !lamp_test_active_flag_o && !$past(lamp_test_active_flag_o) && !$past(rst_i)
        && !$past(rst_i, 2) |-> lamp_o == $past(func_lamp_i))
        else $error("idle lamps not functional");
    chk_walk_shape: assert property (lamp_test_active_flag_o |->
        lamp_o == '0 || (&lamp_o) || $onehot(lamp_o) || $onehot(~lamp_o))
        else $error("bad test lamp pattern");
endmodule : lt_seq_chk

bind lt_seq lt_seq_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
    .func_lamp_i, .lamp_o, .lamp_test_active_flag_o, .test_init_evt_o, .target_clear_o);

// ==== lt_ctl_model.sv ====
// Purpose: Control input source for the lamp test.
// Assumes: Lines idle low when not pressed.
// Notes: A short minimum is used only where a pulse must be refused.
`timescale 1ns/1ps
module lt_ctl_model (
    input wire logic clk_i,
    output logic [7:0] trig_o
);
    int held;
    initial begin
        trig_o = 8'h00;
        held = 0;
    end
    always @(posedge clk_i) begin
        held <= (trig_o != 8'h00) ? held + 1 : 0;
    end
    task press(input int line);
        @(posedge clk_i);
        trig_o[line] <= 1'h1;
    endtask : press
    task let_go(input int min);
        do begin
            @(posedge clk_i);
        end while (held < min);
        trig_o <= 8'h00;
    endtask : let_go
endmodule : lt_ctl_model

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the lamp test sequencer.
// Assumes: Shortened qualify, step and stage one counts.
// Notes: Walk order is judged from lamp changes while active.
`timescale 1ns/1ps
`include "lt_cfg.svh"
module tb_top;
    localparam int QC = 20;
    localparam int SC = 10;
    localparam int S1C = 200;
    logic clk_i, rst_i, cyc, stb, we, btn, ack, act, evt, clr;
    logic [3:0] adr, sel, be;
    logic [31:0] wd, rd, dato;
    logic [7:0] trig;
    logic [`LT_LAMPS-1:0] func, lamp, prev;
    int err_count, tests_run, on_k, off_k, clrs, waited;
    lt_ctl_model u_ctl (.clk_i(clk_i), .trig_o(trig));
    lt_seq #(.QUAL_CYC(QC), .STEP_CYC(SC), .STAGE1_CYC(S1C)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(dato),
        .trig_i(trig), .reset_btn_i(btn), .func_lamp_i(func), .lamp_o(lamp),
        .lamp_test_active_flag_o(act), .test_init_evt_o(evt), .target_clear_o(clr));
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    task complete_run;
        $display("Checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task tmo;
        err_count++;
        $display("Error %0t: wait timed out", $time);
        complete_run();
    endtask : tmo
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= be;
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'h1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) tmo();
        rd = dato;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : bus
    task wait_act(input logic v, input int max);
        int n;
        n = 0;
        while (act !== v && n < max) begin
            @(negedge clk_i);
            n++;
        end
        waited = n;
        if (n >= max) tmo();
    endtask : wait_act
    task pulse_btn;
        @(posedge clk_i);
        btn <= 1'h1;
        repeat (8) @(posedge clk_i);
        btn <= 1'h0;
    endtask : pulse_btn
    // Each new lamp pattern in a walk must be the next lamp in column order.
    always @(negedge clk_i) begin
        if (clr === 1'h1) clrs++;
        if (evt === 1'h1) begin
            on_k = 0;
            off_k = 0;
        end else if (act === 1'h1 && lamp !== prev) begin
            if ($onehot(lamp)) begin
                check(lamp, {2'h0, 62'h1 << on_k});
                on_k++;
            end
            if ($onehot(~lamp)) begin
                check(lamp, {2'h0, ~(62'h1 << off_k)});
                off_k++;
            end
        end
        prev = lamp;
    end
    task t_regs;
        bus(1'h1, 4'h0, 32'h0000_0007);
        be = 4'hE;
        bus(1'h1, 4'h0, 32'h0000_0000);
        be = 4'hF;
        bus(1'h0, 4'h0, 32'h0000_0000);
        check(rd, 32'h0000_0007);
        bus(1'h0, 4'h2, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        u_ctl.press(3);
        u_ctl.let_go(5);
        repeat (40) @(negedge clk_i);
        check(act, 1'h0);
    endtask : t_regs
    task t_full;
        @(posedge clk_i);
        func <= {30'h0000_0000, 32'hA5A5_0F0F};
        u_ctl.press(3);
        wait_act(1'h1, 60);
        check(lamp, {2'h0, {62{1'h1}}});
        pulse_btn();
        func <= {30'h2AAA_AAAA, 32'h1234_5678};
        u_ctl.let_go(QC + 4);
        wait_act(1'h0, 1500);
        check(on_k, `LT_LAMPS);
        check(off_k, `LT_LAMPS);
        check(clrs, 0);
        check(lamp, {2'h0, func});
        bus(1'h0, 4'h8, 32'h0000_0000);
        check(rd, 32'h1234_5678);
        bus(1'h0, 4'h4, 32'h0000_0000);
        check(rd, 32'h0001_0000);
        be = 4'h4;
        bus(1'h1, 4'h4, 32'h0001_0000);
        be = 4'hF;
        bus(1'h0, 4'h4, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        pulse_btn();
        repeat (8) @(negedge clk_i);
        check(clrs, 1);
    endtask : t_full
    task t_abort;
        u_ctl.press(3);
        wait_act(1'h1, 60);
        u_ctl.let_go(QC + 4);
        repeat (100) @(negedge clk_i);
        u_ctl.press(3);
        wait_act(1'h0, QC + 20);
        check(lamp, {2'h0, func});
        u_ctl.let_go(QC + 4);
    endtask : t_abort
    task t_tmo;
        bus(1'h1, 4'h0, 32'h0000_000B);
        u_ctl.press(3);
        repeat (40) @(negedge clk_i);
        check(act, 1'h0);
        u_ctl.let_go(QC + 4);
        u_ctl.press(5);
        wait_act(1'h1, 60);
        wait_act(1'h0, 260);
        check(waited, S1C);
        check(trig[5], 1'h1);
        repeat (40) @(negedge clk_i);
        check(act, 1'h0);
        u_ctl.let_go(QC + 4);
    endtask : t_tmo
    initial begin
        {rst_i, cyc, stb, we, btn} = 5'h10;
        {adr, wd} = 36'h0;
        {sel, be} = 8'h0F;
        func = '0;
        prev = '0;
        {err_count, tests_run, on_k, off_k, clrs} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_full();
        t_abort();
        t_tmo();
        complete_run();
    end
    // A hang anywhere, the control model included, still ends in the verdict.
    initial begin
        repeat (20000) @(posedge clk_i);
        tmo();
    end
endmodule : tb_top
